// File: design/wpf_pkg.sv
// package for the wake packet filter register bank: register indices,
// field positions, reset values and the carrier structs.
// assumes one 100 MHz core clock and a 32-bit Avalon-MM register port.
package wpf_pkg;

    // register indices; the byte address is four times the index
    localparam logic [10:0] WPF_IDX_CFG      = 11'h4a0; // filter configuration
    localparam logic [10:0] WPF_IDX_STS      = 11'h4a1; // filter status
    localparam logic [10:0] WPF_IDX_MAC_54   = 11'h4a2; // match address bytes 5,4
    localparam logic [10:0] WPF_IDX_MAC_32   = 11'h4a3; // match address bytes 3,2
    localparam logic [10:0] WPF_IDX_MAC_10   = 11'h4a4; // match address bytes 1,0
    localparam logic [10:0] WPF_IDX_PW_10    = 11'h4a5; // password bytes 1,0
    localparam logic [10:0] WPF_IDX_PW_32    = 11'h4a6; // password bytes 3,2
    localparam logic [10:0] WPF_IDX_PW_54    = 11'h4a7; // password bytes 5,4
    localparam logic [10:0] WPF_IDX_IRQ_STS  = 11'h4a8; // sticky event bits
    localparam logic [10:0] WPF_IDX_IRQ_MASK = 11'h4a9; // event mask

    // configuration fields
    localparam int          WPF_CFG_CRC_GATE  = 12;
    localparam int          WPF_CFG_WOL_EN    = 7;
    localparam int          WPF_CFG_SECURE_EN = 5;
    localparam int          WPF_CFG_MAGIC_IRQ = 0;
    localparam logic [15:0] WPF_CFG_RESET     = 16'h1081;
    localparam logic [15:0] WPF_CFG_RW_MASK   = 16'h17e1; // bit 11 is not writable, reads 0

    // status fields
    localparam int          WPF_STS_SRC_SEL = 12;
    localparam int          WPF_STS_SFD     = 7;
    localparam int          WPF_STS_CRC     = 6;
    localparam int          WPF_STS_HACK    = 5;
    localparam int          WPF_STS_MAGIC   = 0;
    localparam logic [15:0] WPF_STS_RESET   = 16'h1000;
    localparam logic [15:0] WPF_DATA_RESET  = 16'h0000;

    // interrupt status / mask layout
    localparam int          WPF_IRQ_W      = 4;
    localparam int          WPF_IRQ_MAGIC  = 0;
    localparam int          WPF_IRQ_SFD    = 1;
    localparam int          WPF_IRQ_CRC    = 2;
    localparam int          WPF_IRQ_HACK   = 3;
    localparam logic [3:0]  WPF_IRQ_RESET  = 4'h0;

    // cycles after reset release before the synchronised strap is valid:
    // both sync flops must refill after reset before the load may sample them
    localparam logic [1:0]  WPF_STRAP_SETTLE = 2'h3;

    // one received frame, presented for one cycle at frame_end
    typedef struct packed {
        logic        frame_end;  // qualifies the fields below
        logic        frame_start_error_flag;  // frame started without a proper delimiter
        logic        crc_bad;    // frame check sequence failed
        logic        is_magic;   // payload carries the magic sync pattern
        logic [47:0] dest_addr;  // byte k at bits 8k+7:8k, byte 5 most significant
        logic [47:0] password;   // byte k at bits 8k+7:8k
    } wpf_frame_t;

    // filtered events, one-cycle pulses
    typedef struct packed {
        logic sfd;
        logic crc;
        logic hack;
        logic magic;
    } wpf_event_t;

endpackage : wpf_pkg

// File: design/wpf_sync.sv
// two-flop synchroniser for a single level from outside the clock domain.
// assumes the level is slow next to core_clk; glitches shorter than a cycle may be missed.
`timescale 1ns/1ps
module wpf_sync (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // level in and out
    input  wire logic async_i,
    output logic      sync_o
);
    // first stage only feeds the second stage
    logic meta_q;
    logic sync_q;

    // both stages clear to a constant under reset
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule : wpf_sync

// File: design/wpf_match.sv
// frame classifier: compares a received frame against the programmed
// address and password and turns it into registered event pulses.
// assumes frame fields come from receive logic on the same clock.
`timescale 1ns/1ps
module wpf_match (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    // received frame and settings
    input  wire wpf_pkg::wpf_frame_t frame_i,
    input  wire logic [47:0]         match_addr_i,
    input  wire logic [47:0]         password_i,
    input  wire logic                wol_en_i,
    input  wire logic                secure_en_i,
    input  wire logic                crc_gate_i,
    // filtered events
    output wpf_pkg::wpf_event_t      event_o
);
    import wpf_pkg::*;

    wpf_event_t ev_q;        // registered events
    wpf_event_t ev_d;        // next events
    logic       addr_ok;     // destination equals programmed bytes
    logic       pw_ok;       // password equals stored bytes, or password checking is off
    logic       gated;       // bad crc with crc gating on suppresses magic indications
    logic       magic_frame; // addressed magic packet, after crc gating, before the password check

    assign addr_ok     = (frame_i.dest_addr == match_addr_i);
    assign pw_ok       = !secure_en_i || (frame_i.password == password_i);
    assign gated       = crc_gate_i && frame_i.crc_bad;
    assign magic_frame = frame_i.frame_end && wol_en_i && frame_i.is_magic && addr_ok && !gated;

    // event decode, all qualified by the frame strobe
    assign ev_d.sfd   = frame_i.frame_end && frame_i.frame_start_error_flag;
    assign ev_d.crc   = frame_i.frame_end && frame_i.crc_bad;
    assign ev_d.hack  = magic_frame && !pw_ok;
    assign ev_d.magic = magic_frame && pw_ok;

    // register the events so the bank sees clean pulses
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            ev_q <= '0;
        else
            ev_q <= ev_d;
    end

    assign event_o = ev_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_crc_gate_blocks: assert property (
        frame_i.frame_end && frame_i.crc_bad && crc_gate_i |=> !ev_q.magic && !ev_q.hack)
        else $error("bad crc frame produced a magic indication");
    a_pw_not_checked: assert property (
        frame_i.frame_end && !secure_en_i |=> !ev_q.hack)
        else $error("password flagged while checking disabled");
    a_addr_mismatch: assert property (
        frame_i.frame_end && (frame_i.dest_addr != match_addr_i) |=> !ev_q.magic)
        else $error("magic accepted with wrong address");
endmodule : wpf_match

// File: design/wpf_regs.sv
// wake packet filter register bank: Avalon-MM slave, configuration, status,
// match address and password storage, interrupt status and mask.
// assumes frame events from receive logic on core_clk and one strap pin.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module wpf_regs (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    // avalon-mm slave, byte addressed
    input  wire logic [12:0]         avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    // strap pin and receive side
    input  wire logic                magic_irq_strap,
    input  wire wpf_pkg::wpf_frame_t frame_i,
    input  wire logic                polarity_irq_i,
    // interrupt outputs
    output logic                     shared_irq_bit,
    output logic                     irq
);
    import wpf_pkg::*;

    logic [15:0]         cfg_q;       // wake_filter_config
    logic [15:0]         sts_q;       // wake_filter_status
    logic [15:0]         mac_54_q;    // match_addr_bytes_5_4
    logic [15:0]         mac_32_q;    // match_addr_bytes_3_2
    logic [15:0]         mac_10_q;    // match_addr_bytes_1_0
    logic [15:0]         pw_10_q;     // password_bytes_1_0
    logic [15:0]         pw_32_q;     // password_bytes_3_2
    logic [15:0]         pw_54_q;     // password_bytes_5_4
    logic [WPF_IRQ_W-1:0] irq_sts_q;  // sticky interrupt status
    logic [WPF_IRQ_W-1:0] irq_mask_q; // interrupt mask
    logic                ack_q;       // answer phase of a bus access
    logic [31:0]         rdata_q;     // registered read data
    logic [1:0]          strap_cnt_q; // settle counter for the strap
    logic                shared_q;    // registered shared interrupt bit
    logic                strap_sync;  // strap after two flops
    wpf_event_t          ev;          // filtered frame events

    // decode, one word per register
    logic [10:0] idx;
    logic        wr_fire;
    logic        rd_fire;
    logic [15:0] wmask;
    logic [15:0] rd_mux;
    logic [47:0] match_addr;
    logic [47:0] password;
    logic        wol_rise;
    logic        magic_irq;

    // build a 16-bit write mask from the two low byte enables
    function automatic logic [15:0] wpf_lane_mask(input logic [3:0] be);
        wpf_lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction : wpf_lane_mask

    // merge write data into a register under lane and field masks
    function automatic logic [15:0] wpf_merge(input logic [15:0] old, input logic [15:0] wd,
                                              input logic [15:0] m);
        wpf_merge = (old & ~m) | (wd & m);
    endfunction : wpf_merge

    assign idx     = avs_address[12:2];
    assign wr_fire = avs_write && ack_q;
    assign rd_fire = avs_read && ack_q;
    assign wmask   = wpf_lane_mask(avs_byteenable);

    // the master holds its request until waitrequest drops: one wait state
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata    = rdata_q;

    // byte 5 most significant, byte k at bits 8k+7:8k
    assign match_addr = {mac_54_q[7:0], mac_54_q[15:8], mac_32_q[7:0], mac_32_q[15:8],
                         mac_10_q[7:0], mac_10_q[15:8]};
    // password bytes 0-3, higher byte in bits 15-8
    // bytes 5,4 from the third password register
    assign password   = {pw_54_q, pw_32_q, pw_10_q};

    // a write that turns wake-on-lan on
    assign wol_rise = wr_fire && (idx == WPF_IDX_CFG) && wmask[WPF_CFG_WOL_EN]
                      && avs_writedata[WPF_CFG_WOL_EN] && !cfg_q[WPF_CFG_WOL_EN];
    // magic packet interrupt qualified by its enable
    assign magic_irq = ev.magic && cfg_q[WPF_CFG_MAGIC_IRQ];

    // read selection; unmapped offsets read zero
    always_comb
    begin
        case (idx)
            WPF_IDX_CFG:      rd_mux = cfg_q;
            WPF_IDX_STS:      rd_mux = sts_q;
            WPF_IDX_MAC_54:   rd_mux = mac_54_q;
            WPF_IDX_MAC_32:   rd_mux = mac_32_q;
            WPF_IDX_MAC_10:   rd_mux = mac_10_q;
            WPF_IDX_PW_10:    rd_mux = pw_10_q;
            WPF_IDX_PW_32:    rd_mux = pw_32_q;
            WPF_IDX_PW_54:    rd_mux = pw_54_q;
            WPF_IDX_IRQ_STS:  rd_mux = {12'h000, irq_sts_q};
            WPF_IDX_IRQ_MASK: rd_mux = {12'h000, irq_mask_q};
            default:          rd_mux = 16'h0000;
        endcase
    end

    // strap passes two flops before it is trusted
    wpf_sync u_strap_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_i  (magic_irq_strap),
        .sync_o   (strap_sync)
    );

    // frame classification against the programmed values
    wpf_match u_match (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .frame_i      (frame_i),
        .match_addr_i (match_addr),
        .password_i   (password),
        .wol_en_i     (cfg_q[WPF_CFG_WOL_EN]),
        .secure_en_i  (cfg_q[WPF_CFG_SECURE_EN]),
        .crc_gate_i   (cfg_q[WPF_CFG_CRC_GATE]),
        .event_o      (ev)
    );

    // bus answer phase and read data capture
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q   <= (avs_read || avs_write) && !ack_q;
            rdata_q <= (avs_read && !ack_q) ? {16'h0000, rd_mux} : rdata_q;
        end
    end

    // settle counter; the strap is sampled once, after release
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            strap_cnt_q <= 2'h0;
        else if (strap_cnt_q != WPF_STRAP_SETTLE)
            strap_cnt_q <= strap_cnt_q + 2'h1;
    end

    // configuration: software fields, strap load of the magic enable
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            cfg_q <= WPF_CFG_RESET;
        else if (wr_fire && idx == WPF_IDX_CFG)
            cfg_q <= wpf_merge(cfg_q, avs_writedata[15:0], wmask & WPF_CFG_RW_MASK);
        else if (strap_cnt_q == WPF_STRAP_SETTLE - 2'h1)
            // strap value replaces the reset default once it has settled
            cfg_q[WPF_CFG_MAGIC_IRQ] <= strap_sync;
    end

    // status: select bit is software writable, flags are hardware set, read clear
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            sts_q <= WPF_STS_RESET;
        else
        begin
            if (wr_fire && idx == WPF_IDX_STS && wmask[WPF_STS_SRC_SEL])
                sts_q[WPF_STS_SRC_SEL] <= avs_writedata[WPF_STS_SRC_SEL];
            // turning wake-on-lan on forces the wake source
            if (wol_rise)
                sts_q[WPF_STS_SRC_SEL] <= 1'b1;
            // a read clears the flags; a same-cycle event still lands
            // frame start error flag
            sts_q[WPF_STS_SFD]   <= ev.sfd || (sts_q[WPF_STS_SFD] && !(rd_fire && idx == WPF_IDX_STS));
            sts_q[WPF_STS_CRC]   <= ev.crc || (sts_q[WPF_STS_CRC] && !(rd_fire && idx == WPF_IDX_STS));
            sts_q[WPF_STS_HACK]  <= ev.hack || (sts_q[WPF_STS_HACK] && !(rd_fire && idx == WPF_IDX_STS));
            sts_q[WPF_STS_MAGIC] <= ev.magic || (sts_q[WPF_STS_MAGIC] && !(rd_fire && idx == WPF_IDX_STS));
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            mac_54_q <= WPF_DATA_RESET;
            mac_32_q <= WPF_DATA_RESET;
            mac_10_q <= WPF_DATA_RESET;
        end
        else if (wr_fire)
        begin
            if (idx == WPF_IDX_MAC_54)
                mac_54_q <= wpf_merge(mac_54_q, avs_writedata[15:0], wmask);
            if (idx == WPF_IDX_MAC_32)
                mac_32_q <= wpf_merge(mac_32_q, avs_writedata[15:0], wmask);
            if (idx == WPF_IDX_MAC_10)
                mac_10_q <= wpf_merge(mac_10_q, avs_writedata[15:0], wmask);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pw_10_q <= WPF_DATA_RESET;
            pw_32_q <= WPF_DATA_RESET;
            pw_54_q <= WPF_DATA_RESET;
        end
        else if (wr_fire)
        begin
            if (idx == WPF_IDX_PW_10)
                pw_10_q <= wpf_merge(pw_10_q, avs_writedata[15:0], wmask);
            if (idx == WPF_IDX_PW_32)
                pw_32_q <= wpf_merge(pw_32_q, avs_writedata[15:0], wmask);
            if (idx == WPF_IDX_PW_54)
                pw_54_q <= wpf_merge(pw_54_q, avs_writedata[15:0], wmask);
        end
    end

    // interrupt mask, software owned
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            irq_mask_q <= WPF_IRQ_RESET;
        else if (wr_fire && idx == WPF_IDX_IRQ_MASK && avs_byteenable[0])
            irq_mask_q <= avs_writedata[WPF_IRQ_W-1:0];
    end

    // sticky interrupt status; set wins over the read clear
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            irq_sts_q <= WPF_IRQ_RESET;
        else
        begin
            irq_sts_q <= (irq_sts_q & {WPF_IRQ_W{!(rd_fire && idx == WPF_IDX_IRQ_STS)}})
                       | {ev.hack, ev.crc, ev.sfd, magic_irq};
        end
    end

    // shared interrupt bit, registered so it is glitch free
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            shared_q <= 1'b0;
        else
            // select wake event or polarity interrupt
            shared_q <= sts_q[WPF_STS_SRC_SEL] ? magic_irq : polarity_irq_i;
    end

    assign shared_irq_bit = shared_q;
    // level interrupt: any unmasked sticky bit
    assign irq            = |(irq_sts_q & irq_mask_q);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // a request is held until it is answered one cycle later
    sequence s_req_waits;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_req_answered;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence

    a_bus_one_wait: assert property (s_req_waits |=> s_req_answered)
        else $error("request not answered after one wait state");
    a_magic_irq_set: assert property (
        ev.magic && cfg_q[WPF_CFG_MAGIC_IRQ] |=> irq_sts_q[WPF_IRQ_MAGIC])
        else $error("magic packet did not set its interrupt bit");
    a_shared_src_sel: assert property (
        !sts_q[WPF_STS_SRC_SEL] |=> shared_irq_bit == $past(polarity_irq_i))
        else $error("shared bit does not follow polarity input");
    a_wol_auto_sel: assert property (
        wol_rise |=> sts_q[WPF_STS_SRC_SEL])
        else $error("enabling wake did not select wake source");
    a_sfd_flag_set: assert property (
        ev.sfd |=> sts_q[WPF_STS_SFD])
        else $error("frame start error flag not set");
    a_crc_flag_set: assert property (
        ev.crc |=> sts_q[WPF_STS_CRC] ##1 sts_q[WPF_STS_CRC] || $past(rd_fire))
        else $error("bad crc flag not set or lost");
    a_hack_flag_set: assert property (
        ev.hack |=> sts_q[WPF_STS_HACK])
        else $error("invalid password flag not set");
    a_magic_flag_set: assert property (
        ev.magic |=> sts_q[WPF_STS_MAGIC])
        else $error("magic status flag not set");
    a_flag_read_clear: assert property (
        rd_fire && idx == WPF_IDX_STS && !ev.magic |=> !sts_q[WPF_STS_MAGIC])
        else $error("status read did not clear magic flag");
    a_match_addr_wr: assert property (
        wr_fire && idx == WPF_IDX_MAC_54 && avs_byteenable[1:0] == 2'h3
        |=> match_addr[47:32] == {$past(avs_writedata[7:0]), $past(avs_writedata[15:8])})
        else $error("match address bytes 5,4 misplaced");
    a_password_wr: assert property (
        wr_fire && idx == WPF_IDX_PW_32 && avs_byteenable[1:0] == 2'h3
        |=> password[31:16] == $past(avs_writedata[15:0]))
        else $error("password bytes 3,2 misplaced");
    a_password_hi_wr: assert property (
        wr_fire && idx == WPF_IDX_PW_54 && avs_byteenable[1:0] == 2'h3
        |=> password[47:40] == $past(avs_writedata[15:8]))
        else $error("password byte 5 misplaced");
endmodule : wpf_regs

// File: dv/wpf_link_model.sv
// link partner model: hands received frames to the filter, one cycle each.
// assumes callers run in the core_clk domain; fields scramble between frames.
`timescale 1ns/1ps
module wpf_link_model (
    // clock
    input  wire logic           core_clk,
    // frame toward the filter
    output wpf_pkg::wpf_frame_t frame_o
);
    import wpf_pkg::*;

    // idle with no frame marker until the first send
    initial frame_o = '0;

    // one frame_end cycle; leftovers are inverted so stale fields never match by luck
    task send(input wpf_frame_t f);
        @(posedge core_clk);
        frame_o <= f;
        @(posedge core_clk);
        frame_o <= {1'b0, ~f[$bits(f)-2:0]};
    endtask : send
endmodule : wpf_link_model

// File: dv/wake_packet_filter_regs_test.sv
// self-checking bench for the wake packet filter register bank.
// assumes wpf_regs, the link model and one 100 MHz clock; reads are checked by a watcher.
`timescale 1ns/1ps
module wake_packet_filter_regs_test;
    import wpf_pkg::*;
    logic                core_clk        = 1'b0;  // core clock
    logic                rst_n           = 1'b0;  // synchronous reset
    logic [12:0]         avs_address     = '0;    // byte address
    logic                avs_read        = 1'b0;  // read request
    logic                avs_write       = 1'b0;  // write request
    logic [31:0]         avs_writedata   = '0;    // write data
    logic [3:0]          avs_byteenable  = '0;    // lanes
    logic [31:0]         avs_readdata;            // read answer
    logic                avs_waitrequest;         // bus stall
    logic                magic_irq_strap = 1'b1;  // strap high until the second reset
    logic                polarity_irq_i  = 1'b0;  // polarity interrupt level
    wpf_frame_t          frame_i;                 // frame from the link model
    logic                shared_irq_bit;          // shared interrupt bit
    logic                irq;                     // level interrupt
    logic [31:0]         exp_q[$];                // expected read data, oldest first
    logic [31:0]         shr_cnt         = '0;    // cycles with shared bit high
    int                  err_count       = 0;     // mismatches
    int                  checked         = 0;     // comparisons

    wpf_regs wpf_regs_i (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .magic_irq_strap(magic_irq_strap),
        .frame_i(frame_i), .polarity_irq_i(polarity_irq_i), .shared_irq_bit(shared_irq_bit), .irq(irq));
    wpf_link_model link_i (.core_clk(core_clk), .frame_o(frame_i));

    // free-running clock
    always #5 core_clk = ~core_clk;

    // automatic: the read watcher and the main sequence may call it in one time step
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task summarize;
        if (err_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    // watcher: each answered read takes the oldest note; shared bit cycles are counted
    always @(posedge core_clk)
    begin
        if (avs_read && avs_waitrequest === 1'b0)
            check(avs_readdata, exp_q.pop_front());
        if (shared_irq_bit === 1'b1)
            shr_cnt <= shr_cnt + 32'd1;
    end

    // a clock edge passes first, so a strobe is never assigned twice in one step
    task wr(input logic [10:0] i, input logic [15:0] d);
        @(posedge core_clk);
        avs_address    <= {i, 2'b00};
        avs_writedata  <= {16'h0000, d};
        avs_byteenable <= 4'h3;
        avs_write      <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : wr

    task rd(input logic [10:0] i, input logic [15:0] e);
        exp_q.push_back({16'h0000, e});
        @(posedge core_clk);
        avs_address <= {i, 2'b00};
        avs_read    <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
    endtask : rd

    // one frame, then time for the two-stage event path to land
    task frame(input logic sfd, input logic crc, input logic mg, input logic [47:0] a, input logic [47:0] pw);
        link_i.send(wpf_frame_t'({1'b1, sfd, crc, mg, a, pw}));
        repeat (4) @(posedge core_clk);
    endtask : frame

    // polarity level high for five cycles, then let the registered bit settle
    task pol_burst;
        @(posedge core_clk);
        polarity_irq_i <= 1'b1;
        repeat (5) @(posedge core_clk);
        polarity_irq_i <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : pol_burst

    // watchdog: far beyond the few hundred cycles the sequence needs
    initial
    begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        summarize();
    end

    initial
    begin : main
        logic [47:0] m;
        logic [47:0] p;
        logic [31:0] s;
        logic [10:0] idx [6];
        logic [15:0] val [6];
        void'($urandom(87203));
        m = {16'($urandom()), $urandom()};
        p = {16'($urandom()), $urandom()};
        idx = '{WPF_IDX_MAC_54, WPF_IDX_MAC_32, WPF_IDX_MAC_10, WPF_IDX_PW_10, WPF_IDX_PW_32, WPF_IDX_PW_54};
        val = '{{m[39:32], m[47:40]}, {m[23:16], m[31:24]}, {m[7:0], m[15:8]}, p[15:0], p[31:16], p[47:32]};
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(WPF_IDX_CFG, 16'h1081);
        rd(WPF_IDX_STS, 16'h1000);
        for (int k = 0; k < 6; k++)
            rd(idx[k], 16'h0000);
        for (int k = 0; k < 6; k++)
            wr(idx[k], val[k]);
        for (int k = 0; k < 6; k++)
            rd(idx[k], val[k]);
        rd(11'h4aa, 16'h0000);
        // matching magic packet, interrupt masked off
        frame(1'b0, 1'b0, 1'b1, m, ~p);
        check(shr_cnt, 32'd1);
        check({31'd0, irq}, 32'd0);
        rd(WPF_IDX_STS, 16'h1001);
        rd(WPF_IDX_IRQ_STS, 16'h0001);
        wr(WPF_IDX_IRQ_MASK, 16'h000f);
        frame(1'b0, 1'b0, 1'b1, m ^ 48'h1, p);
        rd(WPF_IDX_STS, 16'h1000);
        frame(1'b1, 1'b0, 1'b0, ~m, p);
        check({31'd0, irq}, 32'd1);
        rd(WPF_IDX_STS, 16'h1080);
        rd(WPF_IDX_IRQ_STS, 16'h0002);
        // the read clear lands on the answering edge; look once it has settled
        @(posedge core_clk);
        check({31'd0, irq}, 32'd0);
        frame(1'b0, 1'b1, 1'b1, m, p);
        rd(WPF_IDX_STS, 16'h1040);
        wr(WPF_IDX_CFG, 16'h10a1);
        frame(1'b0, 1'b0, 1'b1, m, p ^ 48'h800000000000);
        rd(WPF_IDX_STS, 16'h1020);
        frame(1'b0, 1'b0, 1'b1, m, p);
        rd(WPF_IDX_STS, 16'h1001);
        wr(WPF_IDX_CFG, 16'h1081);
        frame(1'b0, 1'b0, 1'b1, m, ~p);
        rd(WPF_IDX_STS, 16'h1001);
        rd(WPF_IDX_IRQ_STS, 16'h000d);
        // shared bit follows polarity only while select is cleared
        wr(WPF_IDX_STS, 16'h0000);
        rd(WPF_IDX_STS, 16'h0000);
        s = shr_cnt;
        pol_burst();
        check(shr_cnt, s + 32'd5);
        wr(WPF_IDX_CFG, 16'h1001);
        wr(WPF_IDX_CFG, 16'h1081);
        rd(WPF_IDX_STS, 16'h1000);
        pol_burst();
        check(shr_cnt, s + 32'd5);
        // second reset with the strap low: the magic enable must load as zero
        magic_irq_strap <= 1'b0;
        rst_n           <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(WPF_IDX_CFG, 16'h1080);
        rd(WPF_IDX_STS, 16'h1000);
        repeat (3) @(posedge core_clk);
        summarize();
    end
endmodule : wake_packet_filter_regs_test
